// ### dss_pkg.sv
// Shared types and constants of the display scale setting control block.
// Assumes an APB master with 32-bit data and a single 10 MHz clock.
package dss_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_SET  = 8'h04;
  localparam logic [7:0] ADDR_REF  = 8'h08;
  localparam logic [7:0] ADDR_ERR  = 8'h0c;
  localparam logic [7:0] ADDR_ENV  = 8'h10;
  localparam logic [7:0] ADDR_BW   = 8'h14;

  // Command opcodes, written to CMD bits 31:28.
  localparam logic [3:0] OP_AUTO_BW = 4'h1;
  localparam logic [3:0] OP_BW      = 4'h2;
  localparam logic [3:0] OP_IDENT   = 4'h3;
  localparam logic [3:0] OP_VSCALE  = 4'h4;
  localparam logic [3:0] OP_REF     = 4'h5;
  localparam logic [3:0] OP_UNIT    = 4'h6;
  localparam logic [3:0] OP_SWEEP   = 4'h7;

  // Command arguments, CMD bits 27:24.
  localparam logic [3:0] ARG_OFF     = 4'h0;
  localparam logic [3:0] ARG_ON      = 4'h1;
  localparam logic [3:0] ARG_NUM     = 4'h2;
  localparam logic [3:0] ARG_INC     = 4'h3;
  localparam logic [3:0] ARG_DEC     = 4'h4;
  localparam logic [3:0] ARG_AUTO    = 4'h5;
  localparam logic [3:0] ARG_LOG     = 4'h6;
  localparam logic [3:0] ARG_LIN     = 4'h7;
  localparam logic [3:0] ARG_LIN_DEF = 4'h8;

  // Reference units.
  localparam logic [1:0] UNIT_DBM  = 2'h0;
  localparam logic [1:0] UNIT_DBV  = 2'h1;
  localparam logic [1:0] UNIT_DBMV = 2'h2;
  localparam logic [1:0] UNIT_DBUV = 2'h3;

  // Unit offsets from dBm in quarter dB, on a 50 ohm basis.
  localparam logic signed [15:0] OFS_DBV  = -16'sd52;
  localparam logic signed [15:0] OFS_DBMV = 16'sd188;
  localparam logic signed [15:0] OFS_DBUV = 16'sd428;

  // Error numbers.
  localparam logic [7:0] ERR_REF   = 8'h22;
  localparam logic [7:0] ERR_LIN   = 8'h23;
  localparam logic [7:0] ERR_LOG   = 8'h24;
  localparam logic [7:0] ERR_BW    = 8'h20;
  localparam logic [7:0] ERR_IDENT = 8'h65;

  // Amplitude limits and steps, quarter dB except the log scale values LOG_MIN, LOG_MAX and DELTA_MAX in dB.
  localparam logic signed [15:0] Q_DB        = 16'sd4;
  localparam logic signed [15:0] Q_HALF      = 16'sd2;
  localparam logic signed [15:0] REF_MIN_DBM = -16'sd520;
  localparam logic signed [15:0] REF_MAX_DBM = 16'sd160;
  localparam logic signed [15:0] LIN_MIN_DBV = -16'sd592;
  localparam logic signed [15:0] LIN_MAX_DBV = 16'sd36;
  localparam logic signed [15:0] EIGHTH_Q    = 16'sd72;
  localparam logic signed [15:0] STEP6_Q     = 16'sd24;
  localparam logic signed [15:0] STEP8_Q     = 16'sd32;
  localparam logic [3:0] LOG_MIN   = 4'd1;
  localparam logic [3:0] LOG_MAX   = 4'd15;
  localparam logic [3:0] DELTA_MAX = 4'd4;

  // Span, band and bandwidth codes.
  localparam logic [4:0] SPAN_50K   = 5'd11;
  localparam logic [4:0] SPAN_50M   = 5'd23;
  localparam logic [4:0] SPAN_BW_MAX = 5'd18;
  localparam logic [3:0] BAND_LOW_MAX = 4'd5;
  localparam logic [2:0] BW_MAX     = 3'd6;

  // Power-up values.
  localparam logic [3:0]         RST_LOG  = 4'd10;
  localparam logic signed [15:0] RST_REF  = 16'sd0;
  localparam logic [2:0]         RST_BW   = 3'd6;

  typedef struct packed {
    logic [3:0]         op;
    logic [3:0]         arg;
    logic               unit_given;
    logic [1:0]         unit;
    logic [4:0]         pad;
    logic signed [15:0] value;
  } dss_cmd_t;

  typedef struct packed {
    logic [17:0] pad;
    logic        imp75;
    logic        opt75_fitted;
    logic        auto_time;
    logic        fine;
    logic        tracking_generator_on;
    logic [3:0]  band;
    logic [4:0]  span_code;
  } dss_env_t;

  typedef struct packed {
    logic               auto_bandwidth_select;
    logic [2:0]         bandwidth_setting;
    logic [2:0]         sweep_time;
    logic               ident_on;
    logic               ident_active;
    logic               vert_offset;
    logic               trace_shift;
    logic               scale_lin;
    logic [3:0]         log_scale;
    logic signed [15:0] lin_scale_dbv;
    logic signed [15:0] ref_level;
    logic [1:0]         ref_unit;
    logic               delta_amp;
  } dss_disp_t;

endpackage : dss_pkg

// ### dss_ctrl.sv
// Settings logic for display scale, reference level and resolution control.
// Assumes an APB master on pclk; the surroundings write span, band and options into ENV.
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Auto bandwidth picks bandwidth from span to stay calibrated.
// - Auto bandwidth with auto time: bandwidth from span, then sweep time.
// - Auto bandwidth off keeps present bandwidth and clears auto argument.
// - Any non-auto bandwidth command turns auto bandwidth off, except a numeric one above 6 or negative, which gives error 32.
// - Full settings readback omits the auto bandwidth flag.
// - Power-up: auto on, identify off, log 10 dB, 0 dBm, dBm.
// - Identify shifts traces and offsets alternate sweeps.
// - Identify works only at narrow enough span for the band.
// - Single sweeps alternate normal and offset, first one normal.
// - Identify on with tracking generator on gives error 101, no change.
// - Log scale 1 to 15 dB, rounded; otherwise error 36.
// - Linear scale rounds to nearest dB; default is ref level over eight.
// - Linear step follows 1-2-5, or the 1 dB ref step with small steps.
// - Linear scale out of range gives error 35.
// - Log 1 to 4 dB with small steps enters delta amplitude mode.
// - Numeric ref level rounds to 1 dB, 0.25 dB in delta mode; absolute.
// - Ref level out of range gives error 34; no unit means current unit.
// - Ref readback is absolute number in current units.
// - Unit codes dBm 0, dBV 1, dBmV 2, dBuV 3 set ref units.
// - 75 ohm input selects dBmV, 50 ohm selects dBm; override allowed later.
module dss_ctrl (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  output dss_pkg::dss_disp_t    disp
);

  function automatic logic signed [15:0] unit_ofs(input logic [1:0] u);
    case (u)
      dss_pkg::UNIT_DBV:  unit_ofs = dss_pkg::OFS_DBV;
      dss_pkg::UNIT_DBMV: unit_ofs = dss_pkg::OFS_DBMV;
      dss_pkg::UNIT_DBUV: unit_ofs = dss_pkg::OFS_DBUV;
      default:            unit_ofs = 16'sd0;
    endcase
  endfunction : unit_ofs

  // Registered state.
  logic                  auto_bw_reg,  auto_bw_next;
  logic [2:0]            bw_reg,       bw_next;
  logic [2:0]            swt_reg,      swt_next;
  logic                  ident_reg,    ident_next;
  logic                  act_reg;
  logic                  parity_reg,   parity_next;
  logic                  lin_reg,      lin_next;
  logic [3:0]            log_reg,      log_next;
  logic signed [15:0]    lins_reg,     lins_next;
  logic [1:0]            phase_reg,    phase_next;
  logic signed [15:0]    ref_reg,      ref_next;
  logic [1:0]            unit_reg,     unit_next;
  logic                  delta_reg;
  logic                  offs_reg;
  logic [7:0]            err_reg,      err_next;
  logic                  errv_reg,     errv_next;
  dss_pkg::dss_env_t     env_reg,      env_next;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;

  // Bus decode.
  wire                   access    = psel & penable & ~pready_reg;
  wire                   wr        = access & pwrite;
  wire                   hit_cmd   = paddr == dss_pkg::ADDR_CMD;
  wire                   hit_set   = paddr == dss_pkg::ADDR_SET;
  wire                   hit_ref   = paddr == dss_pkg::ADDR_REF;
  wire                   hit_err   = paddr == dss_pkg::ADDR_ERR;
  wire                   hit_env   = paddr == dss_pkg::ADDR_ENV;
  wire                   hit_bw    = paddr == dss_pkg::ADDR_BW;
  wire                   mapped    = hit_cmd | hit_set | hit_ref | hit_err | hit_env | hit_bw;
  wire                   cmd_go    = wr & hit_cmd;
  wire dss_pkg::dss_cmd_t cmd      = pwdata;
  wire dss_pkg::dss_env_t env_wr   = pwdata;

  // Derived values used by several commands.
  wire signed [15:0]     ref_dbm   = ref_reg - unit_ofs(unit_reg);
  wire signed [15:0]     ref_dbv   = ref_dbm + dss_pkg::OFS_DBV;
  wire [1:0]             arg_unit  = cmd.unit_given ? cmd.unit : unit_reg;
  wire signed [15:0]     num_dbm   = cmd.value - unit_ofs(arg_unit);
  wire signed [15:0]     log_rnd   = (cmd.value + dss_pkg::Q_HALF) >>> 2;
  wire signed [15:0]     lin_rnd   = (cmd.value + dss_pkg::Q_HALF) & ~16'sd3;
  wire                   fine      = env_reg.fine;
  wire                   span_ok   = (env_reg.band <= dss_pkg::BAND_LOW_MAX) ?
                                     (env_reg.span_code <= dss_pkg::SPAN_50K) :
                                     (env_reg.span_code <= dss_pkg::SPAN_50M);
  wire [2:0]             bw_span   = (env_reg.span_code >= dss_pkg::SPAN_BW_MAX) ? dss_pkg::BW_MAX :
                                     3'(env_reg.span_code / 5'd3);
  // Linear 1-2-5 step sizes for going up and down from the present phase.
  wire signed [15:0]     lin_up    = (phase_reg == 2'd1) ? dss_pkg::STEP8_Q : dss_pkg::STEP6_Q;
  wire signed [15:0]     lin_dn    = (phase_reg == 2'd2) ? dss_pkg::STEP8_Q : dss_pkg::STEP6_Q;
  wire signed [15:0]     log_step  = ~fine ? 16'(log_reg) * dss_pkg::Q_DB :
                                     (log_reg <= dss_pkg::DELTA_MAX) ? 16'sd1 : dss_pkg::Q_DB;

  always_comb begin
    logic signed [15:0] ref_try;
    logic signed [15:0] lin_try;
    logic               is_inc;
    ref_try      = ref_reg;
    lin_try      = lins_reg;
    is_inc       = cmd.arg == dss_pkg::ARG_INC;
    auto_bw_next = auto_bw_reg;
    bw_next      = bw_reg;
    ident_next   = ident_reg;
    parity_next  = parity_reg;
    lin_next     = lin_reg;
    log_next     = log_reg;
    lins_next    = lins_reg;
    phase_next   = phase_reg;
    ref_next     = ref_reg;
    unit_next    = unit_reg;
    err_next     = err_reg;
    errv_next    = errv_reg;
    env_next     = env_reg;
    // Clear comes first so that an error raised in the same cycle still lands.
    if (wr && hit_err) begin
      errv_next = 1'b0;
    end
    if (wr && hit_env) begin
      env_next = env_wr;
      if (env_wr.opt75_fitted && env_wr.imp75 != env_reg.imp75) begin
        unit_next = env_wr.imp75 ? dss_pkg::UNIT_DBMV : dss_pkg::UNIT_DBM;
        ref_next  = ref_dbm + unit_ofs(unit_next);
      end
    end
    if (cmd_go) begin
      case (cmd.op)
        dss_pkg::OP_AUTO_BW: begin
          auto_bw_next = cmd.arg == dss_pkg::ARG_ON;
        end
        dss_pkg::OP_BW: begin
          if (cmd.arg == dss_pkg::ARG_AUTO) begin
            auto_bw_next = 1'b1;
          end else if (cmd.arg == dss_pkg::ARG_NUM && cmd.value > 16'(dss_pkg::BW_MAX)) begin
            err_next  = dss_pkg::ERR_BW;
            errv_next = 1'b1;
          end else begin
            auto_bw_next = 1'b0;
            if (cmd.arg == dss_pkg::ARG_NUM) begin
              bw_next = cmd.value[2:0];
            end else if (is_inc && bw_reg != dss_pkg::BW_MAX) begin
              bw_next = bw_reg + 3'd1;
            end else if (cmd.arg == dss_pkg::ARG_DEC && bw_reg != 3'd0) begin
              bw_next = bw_reg - 3'd1;
            end
          end
        end
        dss_pkg::OP_IDENT: begin
          if (cmd.arg == dss_pkg::ARG_ON && env_reg.tracking_generator_on) begin
            err_next  = dss_pkg::ERR_IDENT;
            errv_next = 1'b1;
          end else begin
            ident_next  = cmd.arg == dss_pkg::ARG_ON;
            parity_next = 1'b0;
          end
        end
        dss_pkg::OP_SWEEP: begin
          if (act_reg) begin
            parity_next = ~parity_reg;
          end
        end
        dss_pkg::OP_VSCALE: begin
          if (cmd.arg == dss_pkg::ARG_LOG) begin
            if (log_rnd < 16'(dss_pkg::LOG_MIN) || log_rnd > 16'(dss_pkg::LOG_MAX)) begin
              err_next  = dss_pkg::ERR_LOG;
              errv_next = 1'b1;
            end else begin
              lin_next = 1'b0;
              log_next = log_rnd[3:0];
            end
          end else begin
            if (cmd.arg == dss_pkg::ARG_LIN) begin
              lin_try = lin_rnd;
            end else if (cmd.arg == dss_pkg::ARG_LIN_DEF) begin
              lin_try = ref_dbv - dss_pkg::EIGHTH_Q;
            end else if (fine) begin
              ref_try = is_inc ? ref_reg + dss_pkg::Q_DB : ref_reg - dss_pkg::Q_DB;
              lin_try = (is_inc ? ref_dbv + dss_pkg::Q_DB : ref_dbv - dss_pkg::Q_DB) - dss_pkg::EIGHTH_Q;
            end else begin
              lin_try = is_inc ? lins_reg + lin_up : lins_reg - lin_dn;
            end
            if (lin_try < dss_pkg::LIN_MIN_DBV || lin_try > dss_pkg::LIN_MAX_DBV) begin
              err_next  = dss_pkg::ERR_LIN;
              errv_next = 1'b1;
            end else begin
              lin_next  = 1'b1;
              lins_next = lin_try;
              ref_next  = ref_try;
              if (!fine && (is_inc || cmd.arg == dss_pkg::ARG_DEC)) begin
                phase_next = is_inc ? ((phase_reg == 2'd2) ? 2'd0 : phase_reg + 2'd1) :
                                      ((phase_reg == 2'd0) ? 2'd2 : phase_reg - 2'd1);
              end else if (!fine) begin
                phase_next = 2'd0;
              end
            end
          end
        end
        dss_pkg::OP_REF: begin
          if (cmd.arg == dss_pkg::ARG_NUM) begin
            ref_try = (delta_reg ? num_dbm : ((num_dbm + dss_pkg::Q_HALF) & ~16'sd3)) + unit_ofs(unit_reg);
            lin_try = ref_try - unit_ofs(unit_reg) + dss_pkg::OFS_DBV - dss_pkg::EIGHTH_Q;
          end else if (lin_reg) begin
            ref_try = is_inc ? ref_reg + lin_up : ref_reg - lin_dn;
            lin_try = is_inc ? lins_reg + lin_up : lins_reg - lin_dn;
          end else begin
            ref_try = is_inc ? ref_reg + log_step : ref_reg - log_step;
          end
          if (ref_try - unit_ofs(unit_reg) < dss_pkg::REF_MIN_DBM ||
              ref_try - unit_ofs(unit_reg) > dss_pkg::REF_MAX_DBM) begin
            err_next  = dss_pkg::ERR_REF;
            errv_next = 1'b1;
          end else begin
            ref_next = ref_try;
            if (lin_reg) begin
              lins_next = lin_try;
              if (cmd.arg != dss_pkg::ARG_NUM) begin
                phase_next = is_inc ? ((phase_reg == 2'd2) ? 2'd0 : phase_reg + 2'd1) :
                                      ((phase_reg == 2'd0) ? 2'd2 : phase_reg - 2'd1);
              end
            end
          end
        end
        dss_pkg::OP_UNIT: begin
          unit_next = cmd.unit;
          ref_next  = ref_dbm + unit_ofs(cmd.unit);
        end
        default: begin
          err_next = err_reg;
        end
      endcase
    end
    if (auto_bw_next) begin
      bw_next = bw_span;
    end
  end

  assign swt_next = env_reg.auto_time ? (dss_pkg::BW_MAX - bw_reg) : swt_reg;

  wire [31:0] set_word = {8'h00, errv_reg, delta_reg, unit_reg, fine, act_reg, ident_reg,
                          lin_reg, log_reg, lins_reg[11:0]};
  wire [31:0] rd_word  = hit_set ? set_word :
                         hit_ref ? {{16{ref_reg[15]}}, ref_reg} :
                         hit_err ? {23'h000000, errv_reg, err_reg} :
                         hit_env ? 32'(env_reg) :
                         hit_bw  ? {25'h0000000, swt_reg, auto_bw_reg, bw_reg} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_bw_reg <= 1'b1;
      bw_reg      <= dss_pkg::RST_BW;
      ident_reg   <= 1'b0;
      lin_reg     <= 1'b0;
      log_reg     <= dss_pkg::RST_LOG;
      ref_reg     <= dss_pkg::RST_REF;
      unit_reg    <= dss_pkg::UNIT_DBM;
      lins_reg    <= 16'sd0;
      phase_reg   <= 2'd0;
      parity_reg  <= 1'b0;
      swt_reg     <= 3'd0;
      err_reg     <= 8'h00;
      errv_reg    <= 1'b0;
      env_reg     <= '0;
    end else begin
      auto_bw_reg <= auto_bw_next;
      bw_reg      <= bw_next;
      ident_reg   <= ident_next;
      lin_reg     <= lin_next;
      log_reg     <= log_next;
      ref_reg     <= ref_next;
      unit_reg    <= unit_next;
      lins_reg    <= lins_next;
      phase_reg   <= phase_next;
      parity_reg  <= parity_next;
      swt_reg     <= swt_next;
      err_reg     <= err_next;
      errv_reg    <= errv_next;
      env_reg     <= env_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_reg   <= 1'b0;
      delta_reg <= 1'b0;
      offs_reg  <= 1'b0;
    end else begin
      act_reg   <= ident_reg & span_ok;
      // Built from parity_next so that the output is a flop yet in step with act_reg and parity_reg.
      offs_reg  <= ident_reg & span_ok & parity_next;
      delta_reg <= ~lin_reg & fine & (log_reg <= dss_pkg::DELTA_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg  <= (access & ~pwrite) ? rd_word : 32'h00000000;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  assign disp = '{auto_bandwidth_select: auto_bw_reg, bandwidth_setting: bw_reg, sweep_time: swt_reg,
                  ident_on: ident_reg, ident_active: act_reg, vert_offset: offs_reg,
                  trace_shift: offs_reg, scale_lin: lin_reg, log_scale: log_reg,
                  lin_scale_dbv: lins_reg, ref_level: ref_reg, ref_unit: unit_reg, delta_amp: delta_reg};

endmodule : dss_ctrl
`default_nettype wire

// ### dss_chk.sv
// Concurrent checks on the APB side and the display outputs of dss_ctrl.
// Assumes one pclk domain and sees only the ports of the top module.
`timescale 1ns/1ps
`default_nettype none
module dss_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire dss_pkg::dss_disp_t disp
);
  wire               acc  = psel && penable && !pready && pwrite && paddr == dss_pkg::ADDR_CMD;
  wire [3:0]         op   = pwdata[31:28];
  wire [3:0]         arg  = pwdata[27:24];
  wire signed [15:0] val  = pwdata[15:0];
  wire               logc = acc && op == dss_pkg::OP_VSCALE && arg == dss_pkg::ARG_LOG;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_answer_time: assert property (psel && $rose(penable) |=> pready) else $error("answer late");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr) else $error("unmapped not refused");
  a_bw_auto_off: assert property (acc && op == dss_pkg::OP_BW && arg != dss_pkg::ARG_AUTO &&
    (arg != dss_pkg::ARG_NUM || (val >= 16'sh0 && val <= 16'sh6))
    |=> !disp.auto_bandwidth_select) else $error("auto bw kept");
  a_auto_off_keep: assert property (acc && op == dss_pkg::OP_AUTO_BW && arg == dss_pkg::ARG_OFF
    |=> !disp.auto_bandwidth_select && $stable(disp.bandwidth_setting)) else $error("auto off wrong");
  a_log_value: assert property (logc && val >= 16'sh4 && val <= 16'sh3c
    |=> disp.log_scale == 4'((val + 16'sh2) >>> 2) && !disp.scale_lin) else $error("log scale wrong");
  a_log_range: assert property (logc && val >= 16'sh40 |=> $stable(disp.log_scale)) else $error("log range");
  a_unit_select: assert property (acc && op == dss_pkg::OP_UNIT
    |=> disp.ref_unit == $past(pwdata[22:21])) else $error("unit not selected");
  a_delta_mode: assert property (disp.delta_amp
    |-> $past(disp.log_scale) <= 4'h4 && !$past(disp.scale_lin)) else $error("delta mode wrong");
  a_ident_quiet: assert property (!disp.ident_on && !$past(disp.ident_on)
    |-> !disp.vert_offset && !disp.trace_shift) else $error("identify effects while off");
  c_log: cover property (logc);
  c_unit: cover property (acc && op == dss_pkg::OP_UNIT);
  c_refused: cover property (pready && pslverr);
endmodule : dss_chk
bind dss_ctrl dss_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .disp(disp));
`default_nettype wire

// ### dss_host.sv
// APB master model standing in for the remote controller.
// Assumes one pclk domain; released address and data show the inverse of the last value.
`timescale 1ns/1ps
`default_nettype none
module dss_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
  end
  // Read just after a rising edge, pready and prdata still hold what that edge sampled.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask : xfer
endmodule : dss_host
`default_nettype wire

// ### tb_top.sv
// Self-checking bench: command sequences over APB with expected settings.
// Assumes dss_ctrl and the dss_host master model; a cycle ceiling cuts hangs.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, er, v;
  logic [7:0]         paddr;
  logic [31:0]        pwdata, prdata, rd;
  dss_pkg::dss_disp_t disp;
  int                 n_mismatch, samples_checked, cyc;
  dss_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dss_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .disp(disp));
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic [31:0] cmd(logic [3:0] op, logic [3:0] arg, logic [15:0] val);
    dss_pkg::dss_cmd_t c;
    c = '0;
    c.op = op;
    c.arg = arg;
    c.value = val;
    c.unit = val[1:0];
    c.unit_given = (op == dss_pkg::OP_UNIT);
    return c;
  endfunction : cmd
  // Ends at a falling edge so every display output but sweep_time after an ENV span change has landed.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, er);
    @(negedge pclk);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, rd, er);
    check(rd & m, e);
  endtask : rdchk
  task automatic errchk(input logic [7:0] code);
    rdchk(dss_pkg::ADDR_ERR, 32'h1ff, {23'h0, 1'b1, code});
    wr(dss_pkg::ADDR_ERR, 32'h0);
  endtask : errchk
  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check({disp.auto_bandwidth_select, disp.bandwidth_setting, disp.ident_on, disp.log_scale, disp.ref_unit},
      {1'b1, 3'h6, 1'b0, 4'ha, 2'h0});
    check(disp.ref_level, 32'h0);
    rdchk(dss_pkg::ADDR_BW, 32'hf, 32'h8);
    i_host.xfer(1'b0, 8'h18, 32'h0, rd, er);
    check(er, 32'h1);
    wr(dss_pkg::ADDR_ENV, 32'hc);
    check(disp.bandwidth_setting, 32'h4);
    wr(dss_pkg::ADDR_ENV, 32'h80c);
    check(disp.sweep_time, 32'h2);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_BW, dss_pkg::ARG_NUM, 16'h3));
    check({disp.auto_bandwidth_select, disp.bandwidth_setting}, 32'h3);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_AUTO_BW, dss_pkg::ARG_ON, 16'h0));
    check(disp.bandwidth_setting, 32'h4);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_AUTO_BW, dss_pkg::ARG_OFF, 16'h0));
    wr(dss_pkg::ADDR_ENV, 32'h12);
    check({disp.auto_bandwidth_select, disp.bandwidth_setting}, 32'h4);
    rdchk(dss_pkg::ADDR_BW, 32'h8, 32'h0);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_VSCALE, dss_pkg::ARG_LOG, 16'h000b));
    check(disp.log_scale, 32'h3);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_VSCALE, dss_pkg::ARG_LOG, 16'h0040));
    check(disp.log_scale, 32'h3);
    errchk(dss_pkg::ERR_LOG);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_REF, dss_pkg::ARG_NUM, 16'hffd7));
    rdchk(dss_pkg::ADDR_REF, 32'hffffffff, 32'hffffffd8);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_REF, dss_pkg::ARG_INC, 16'h0));
    rdchk(dss_pkg::ADDR_REF, 32'hffffffff, 32'hffffffe4);
    wr(dss_pkg::ADDR_ENV, 32'h412);
    check(disp.delta_amp, 32'h1);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_REF, dss_pkg::ARG_NUM, 16'hffd7));
    rdchk(dss_pkg::ADDR_REF, 32'hffffffff, 32'hffffffd7);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_REF, dss_pkg::ARG_NUM, 16'h00c8));
    errchk(dss_pkg::ERR_REF);
    rdchk(dss_pkg::ADDR_REF, 32'hffffffff, 32'hffffffd7);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_REF, dss_pkg::ARG_NUM, 16'h0));
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_UNIT, dss_pkg::ARG_NUM, 16'h2));
    check(disp.ref_level, 32'hbc);
    for (int u = 0; u < 4; u++) begin
      wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_UNIT, dss_pkg::ARG_NUM, 16'(u)));
      check(disp.ref_unit, u[1:0]);
    end
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_REF, dss_pkg::ARG_NUM, 16'h0190));
    rdchk(dss_pkg::ADDR_REF, 32'hffffffff, 32'h190);
    wr(dss_pkg::ADDR_ENV, 32'h3412);
    check(disp.ref_unit, 32'h2);
    wr(dss_pkg::ADDR_ENV, 32'h1412);
    check(disp.ref_unit, 32'h0);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_VSCALE, dss_pkg::ARG_LIN, 16'h0064));
    errchk(dss_pkg::ERR_LIN);
    check(disp.scale_lin, 32'h0);
    wr(dss_pkg::ADDR_ENV, 32'h212);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_IDENT, dss_pkg::ARG_ON, 16'h0));
    errchk(dss_pkg::ERR_IDENT);
    check(disp.ident_on, 32'h0);
    wr(dss_pkg::ADDR_ENV, 32'hb);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_IDENT, dss_pkg::ARG_ON, 16'h0));
    check({disp.ident_on, disp.ident_active, disp.vert_offset, disp.trace_shift}, 32'hc);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_SWEEP, dss_pkg::ARG_NUM, 16'h0));
    v = disp.vert_offset;
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_SWEEP, dss_pkg::ARG_NUM, 16'h0));
    check({disp.vert_offset, disp.trace_shift}, {30'h0, ~v, ~v});
    wr(dss_pkg::ADDR_ENV, 32'hc);
    check(disp.ident_active, 32'h0);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_VSCALE, dss_pkg::ARG_LIN, 16'hff9c));
    check({disp.scale_lin, disp.lin_scale_dbv}, 32'h1ff9c);
    wr(dss_pkg::ADDR_CMD, cmd(dss_pkg::OP_VSCALE, dss_pkg::ARG_INC, 16'h0));
    check({disp.scale_lin, disp.lin_scale_dbv}, 32'h1ffb4);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
